// ==== rtl/decode_pkg.sv ====
package decode_pkg;

  // operand addressing modes, seventeen in all
  typedef enum logic [4:0] {
    M_INH, M_IMM, M_SDIR, M_LDIR, M_NOIDX, M_SIDX, M_LIDX,
    M_SIND, M_LIND, M_SINDX, M_LINDX, M_RELD, M_RELI,
    M_BITD, M_BITI, M_BITDR, M_BITIR
  } mode_t;

  // operations whose addressing or flags this unit handles
  typedef enum logic [4:0] {
    OP_LOAD, OP_BIT_COMPARE, OP_INTERRUPT_RETURN, OP_JUMP_REL,
    OP_BTJT, OP_BTJF, OP_CLR, OP_COMPLEMENT, OP_NEG, OP_INC,
    OP_DEC, OP_BSET, OP_BRES, OP_RLC, OP_RRC, OP_SLL, OP_SRL,
    OP_SRA, OP_SWAP
  } op_t;

  // relative jump conditions
  typedef enum logic [3:0] {
    C_ALWAYS, C_NEVER, C_EQUAL, C_NOT_EQUAL, C_MINUS, C_PLUS,
    C_CARRY_SET, C_CARRY_CLEAR, C_HALF_SET, C_HALF_CLEAR,
    C_MASK_SET, C_MASK_CLEAR, C_UNSIGNED_GREATER,
    C_EXT_LINE_HIGH, C_EXT_LINE_LOW
  } cond_t;

  // condition code register layout
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam logic [4:0] CC_RESET = 5'h08;
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  localparam logic [2:0] POP_LAST = 3'h4;
  localparam logic [2:0] Y_PREFIX_LEN = 3'h1;

  // read-modify-write memory operations
  function automatic logic is_rmw(input op_t op);
    case (op)
      OP_CLR, OP_COMPLEMENT, OP_NEG, OP_BSET, OP_BRES, OP_BTJT,
      OP_BTJF, OP_INC, OP_DEC, OP_RLC, OP_RRC, OP_SLL, OP_SRL,
      OP_SRA, OP_SWAP: is_rmw = 1'b1;
      default:         is_rmw = 1'b0;
    endcase
  endfunction

  // modes that carry a 16-bit address or pointer
  function automatic logic is_long(input mode_t m);
    is_long = (m == M_LDIR) || (m == M_LIDX) || (m == M_LIND) ||
              (m == M_LINDX);
  endfunction

  // modes that add an index register
  function automatic logic is_indexed(input mode_t m);
    is_indexed = (m == M_NOIDX) || (m == M_SIDX) || (m == M_LIDX) ||
                 (m == M_SINDX) || (m == M_LINDX);
  endfunction

endpackage

// ==== rtl/decode_if.sv ====
`timescale 1ns/1ps
interface decode_if;
  import decode_pkg::*;
  mode_t       mode;
  op_t         op;
  cond_t       cond;
  logic        idx_y;
  logic [7:0]  byte1;
  logic [7:0]  byte2;
  logic [15:0] ptr;
  logic [7:0]  xr;
  logic [7:0]  yr;
  logic [15:0] pc;
  logic [4:0]  cc;
  logic        ext_line;
  logic        bit_val;
  logic [15:0] ea;
  logic [15:0] target;
  logic [2:0]  len;
  logic        taken;

  modport core_mp (output mode, op, cond, idx_y, byte1, byte2, ptr,
                   xr, yr, pc, cc, ext_line, bit_val,
                   input ea, target, len, taken);
  modport ea_mp (input mode, idx_y, byte1, byte2, ptr, xr, yr, pc,
                 output ea, target, len);
  modport br_mp (input op, cond, cc, ext_line, bit_val,
                 output taken);
endinterface

// ==== rtl/ea_calc.sv ====
`timescale 1ns/1ps
module ea_calc
  import decode_pkg::*;
(
  decode_if.ea_mp d
);

  logic [7:0]  idx;
  logic [7:0]  disp;
  logic [15:0] idx16;

  // effective address, jump target and operand length
  always_comb
  begin
    idx   = d.idx_y ? d.yr : d.xr;
    idx16 = {PAGE_ZERO_HI, idx};
    disp  = d.byte1;
    d.ea  = {PAGE_ZERO_HI, d.byte1};
    d.len = 3'h0;
    case (d.mode)
      M_INH:   d.len = 3'h0;
      M_IMM:   d.len = 3'h1;
      // short form stays in page zero
      M_SDIR:  d.len = 3'h1;
      // long form reaches all 64 Kbyte
      M_LDIR:
      begin
        d.ea  = {d.byte1, d.byte2};
        d.len = 3'h2;
      end
      // no offset costs nothing with x
      M_NOIDX:
      begin
        d.ea  = idx16;
        d.len = 3'h0;
      end
      M_SIDX:
      begin
        d.ea  = {PAGE_ZERO_HI, d.byte1} + idx16; // up to 01FE
        d.len = 3'h1;
      end
      M_LIDX:
      begin
        d.ea  = {d.byte1, d.byte2} + idx16;
        d.len = 3'h2;
      end
      M_SIND:
      begin
        d.ea  = {PAGE_ZERO_HI, d.ptr[7:0]};
        d.len = 3'h2;
      end
      M_LIND:
      begin
        d.ea  = d.ptr;
        d.len = 3'h2;
      end
      M_SINDX:
      begin
        d.ea  = {PAGE_ZERO_HI, d.ptr[7:0]} + idx16;
        d.len = 3'h2;
      end
      M_LINDX:
      begin
        d.ea  = d.ptr + idx16;
        d.len = 3'h2;
      end
      M_RELD:  d.len = 3'h1;
      M_RELI:
      begin
        disp  = d.ptr[7:0];
        d.len = 3'h2;
      end
      M_BITD:  d.len = 3'h1;
      M_BITI:
      begin
        d.ea  = {PAGE_ZERO_HI, d.ptr[7:0]};
        d.len = 3'h2;
      end
      M_BITDR:
      begin
        disp  = d.byte2;
        d.len = 3'h2;
      end
      M_BITIR:
      begin
        disp  = d.byte2;
        d.ea  = {PAGE_ZERO_HI, d.ptr[7:0]};
        d.len = 3'h3;
      end
      default: d.len = 3'h0;
    endcase
    // second index costs a prefix byte
    if (is_indexed(d.mode) && d.idx_y)
      d.len = d.len + Y_PREFIX_LEN;
    // pc already points past the jump
    d.target = d.pc + {{8{disp[7]}}, disp};
  end

endmodule

// ==== rtl/branch_cond.sv ====
`timescale 1ns/1ps
module branch_cond
  import decode_pkg::*;
(
  decode_if.br_mp d
);

  logic cond_ok;

  // condition evaluation, one flag at a time except ugt, which tests c and z
  always_comb
  begin
    case (d.cond)
      C_ALWAYS:           cond_ok = 1'b1;
      C_NEVER:            cond_ok = 1'b0;
      C_EQUAL:            cond_ok = d.cc[FLAG_Z];
      C_NOT_EQUAL:        cond_ok = !d.cc[FLAG_Z];
      C_MINUS:            cond_ok = d.cc[FLAG_N];
      C_PLUS:             cond_ok = !d.cc[FLAG_N];
      C_CARRY_SET:        cond_ok = d.cc[FLAG_C];
      C_CARRY_CLEAR:      cond_ok = !d.cc[FLAG_C];
      C_HALF_SET:         cond_ok = d.cc[FLAG_H];
      C_HALF_CLEAR:       cond_ok = !d.cc[FLAG_H];
      C_MASK_SET:         cond_ok = d.cc[FLAG_I];
      C_MASK_CLEAR:       cond_ok = !d.cc[FLAG_I];
      C_UNSIGNED_GREATER: cond_ok = !(d.cc[FLAG_C] | d.cc[FLAG_Z]);
      // level of the external interrupt line
      C_EXT_LINE_HIGH:    cond_ok = d.ext_line;
      C_EXT_LINE_LOW:     cond_ok = !d.ext_line;
      default:            cond_ok = 1'b0;
    endcase
    // bit-test jumps follow the tested bit
    case (d.op)
      OP_JUMP_REL: d.taken = cond_ok;
      OP_BTJT:     d.taken = d.bit_val;
      OP_BTJF:     d.taken = !d.bit_val;
      default:     d.taken = 1'b0;
    endcase
  end

endmodule

// ==== rtl/addr_flag_decode.sv ====
// Summary of operation
// - seventeen addressing modes in seven families are decoded.
// - long forms give 16-bit addresses, one more byte in direct and indexed forms.
// - short direct form addresses page zero only, 0000 to 00FF.
// - read-modify-write operations accept short addressing only.
// - relative jumps add signed byte to next-instruction pc.
// - no-offset indexing adds no byte with x, one with y.
// - bit compare ands acc with memory, sets only n and z.
// - interrupt return pops cc, acc, x, then pc.
// - conditional jumps test one flag; ugt needs c and z clear.
// - two jumps test the external interrupt line level.
// - bit-test jumps branch on a page-zero bit, copy it to carry.
`timescale 1ns/1ps
module addr_flag_decode
  import decode_pkg::*;
(
  input  logic        clk_in,
  input  logic        nrst_in,
  input  logic        valid_in,
  input  op_t         op_in,
  input  mode_t       mode_in,
  input  cond_t       cond_in,
  input  logic        idx_y_in,
  input  logic [7:0]  byte1_in,
  input  logic [7:0]  byte2_in,
  input  logic [15:0] ptr_in,
  input  logic [7:0]  acc_in,
  input  logic [7:0]  x_in,
  input  logic [7:0]  y_in,
  input  logic [15:0] pc_in,
  input  logic [7:0]  mem_in,
  input  logic [2:0]  bit_sel_in,
  input  logic        ext_line_in,
  input  logic [7:0]  stack_data_in,
  output logic        done_out,
  output logic        busy_out,
  output logic        illegal_out,
  output logic [15:0] ea_out,
  output logic [2:0]  len_out,
  output logic        taken_out,
  output logic [15:0] pc_out,
  output logic [7:0]  result_out,
  output logic [4:0]  cc_out,
  output logic [7:0]  acc_out,
  output logic [7:0]  x_out,
  output logic        stack_pop_out
);

  typedef enum logic [0:0] {ST_IDLE, ST_POP} state_t;

  decode_if d ();

  state_t      state_r;
  logic [2:0]  pop_cnt_r;
  logic [4:0]  cc_r;
  logic [4:0]  cc_nxt;
  logic [7:0]  res_nxt;
  logic [7:0]  and_val;
  logic [15:0] pc_pop_r;
  logic        accept;
  logic        bad_mode;

  // operand and condition sub-blocks
  // seventeen modes decoded
  ea_calc u_ea (.d(d));
  branch_cond u_br (.d(d));

  // request fields onto the shared carrier
  assign d.mode     = mode_in;
  assign d.op       = op_in;
  assign d.cond     = cond_in;
  assign d.idx_y    = idx_y_in;
  assign d.byte1    = byte1_in;
  assign d.byte2    = byte2_in;
  assign d.ptr      = ptr_in;
  assign d.xr       = x_in;
  assign d.yr       = y_in;
  assign d.pc       = pc_in;
  assign d.cc       = cc_r;
  assign d.ext_line = ext_line_in;
  assign d.bit_val  = mem_in[bit_sel_in];

  // requests while popping the stack are ignored
  assign accept  = valid_in && (state_r == ST_IDLE);
  assign and_val = acc_in & mem_in;
  // long modes refused for memory rewrites
  assign bad_mode = is_rmw(op_in) && is_long(mode_in);

  // flag and result effects of one operation
  always_comb
  begin
    cc_nxt  = cc_r;
    res_nxt = mem_in;
    case (op_in)
      // only n and z, result discarded
      OP_BIT_COMPARE:
      begin
        cc_nxt[FLAG_N] = and_val[7];
        cc_nxt[FLAG_Z] = (and_val == 8'h00);
      end
      OP_BTJT, OP_BTJF: cc_nxt[FLAG_C] = d.bit_val;
      OP_CLR:           res_nxt = 8'h00;
      OP_COMPLEMENT:
      begin
        res_nxt        = ~mem_in;
        cc_nxt[FLAG_C] = 1'b1;
      end
      OP_NEG:
      begin
        res_nxt        = 8'h00 - mem_in;
        cc_nxt[FLAG_C] = (mem_in != 8'h00);
      end
      OP_INC:           res_nxt = mem_in + 8'h01;
      OP_DEC:           res_nxt = mem_in - 8'h01;
      OP_BSET:          res_nxt = mem_in | (8'h01 << bit_sel_in);
      OP_BRES:          res_nxt = mem_in & ~(8'h01 << bit_sel_in);
      OP_RLC:
      begin
        res_nxt        = {mem_in[6:0], cc_r[FLAG_C]};
        cc_nxt[FLAG_C] = mem_in[7];
      end
      OP_RRC:
      begin
        res_nxt        = {cc_r[FLAG_C], mem_in[7:1]};
        cc_nxt[FLAG_C] = mem_in[0];
      end
      OP_SLL:
      begin
        res_nxt        = {mem_in[6:0], 1'b0};
        cc_nxt[FLAG_C] = mem_in[7];
      end
      OP_SRL:
      begin
        res_nxt        = {1'b0, mem_in[7:1]};
        cc_nxt[FLAG_C] = mem_in[0];
      end
      OP_SRA:
      begin
        res_nxt        = {mem_in[7], mem_in[7:1]};
        cc_nxt[FLAG_C] = mem_in[0];
      end
      OP_SWAP:          res_nxt = {mem_in[3:0], mem_in[7:4]};
      default:          res_nxt = mem_in;
    endcase
    // n and z follow the rewritten byte
    case (op_in)
      OP_CLR, OP_COMPLEMENT, OP_NEG, OP_INC, OP_DEC, OP_RLC,
      OP_RRC, OP_SLL, OP_SRL, OP_SRA, OP_SWAP:
      begin
        cc_nxt[FLAG_N] = res_nxt[7];
        cc_nxt[FLAG_Z] = (res_nxt == 8'h00);
      end
      default: ;
    endcase
  end

  // sequencer for the stack pops
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state_r       <= ST_IDLE;
      pop_cnt_r     <= 3'h0;
      stack_pop_out <= 1'b0;
      busy_out      <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (accept && op_in == OP_INTERRUPT_RETURN && !bad_mode)
          begin
            state_r       <= ST_POP;
            pop_cnt_r     <= 3'h0;
            stack_pop_out <= 1'b1;
            busy_out      <= 1'b1;
          end
        end
        ST_POP:
        begin
          pop_cnt_r <= pop_cnt_r + 3'h1;
          if (pop_cnt_r == POP_LAST)
          begin
            state_r       <= ST_IDLE;
            stack_pop_out <= 1'b0;
            busy_out      <= 1'b0;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // condition codes, acc and x restored by the pops
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      cc_r     <= CC_RESET; // interrupts masked after reset
      acc_out  <= 8'h00;
      x_out    <= 8'h00;
      pc_pop_r <= 16'h0000;
    end
    else if (state_r == ST_POP)
    begin
      // pop order cc, acc, x, pc high, pc low
      case (pop_cnt_r)
        3'h0:    cc_r     <= stack_data_in[4:0];
        3'h1:    acc_out  <= stack_data_in;
        3'h2:    x_out    <= stack_data_in;
        3'h3:    pc_pop_r <= {stack_data_in, pc_pop_r[7:0]};
        default: pc_pop_r <= {pc_pop_r[15:8], stack_data_in};
      endcase
    end
    else if (accept && !bad_mode)
      cc_r <= cc_nxt;
  end

  // answer of a decoded operation, one cycle after the request, six for interrupt return
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      done_out    <= 1'b0;
      illegal_out <= 1'b0;
      ea_out      <= 16'h0000;
      len_out     <= 3'h0;
      taken_out   <= 1'b0;
      pc_out      <= 16'h0000;
      result_out  <= 8'h00;
    end
    else
    begin
      done_out    <= 1'b0;
      illegal_out <= 1'b0;
      if (state_r == ST_POP && pop_cnt_r == POP_LAST)
      begin
        done_out <= 1'b1;
        pc_out   <= {pc_pop_r[15:8], stack_data_in};
      end
      else if (accept && op_in != OP_INTERRUPT_RETURN)
      begin
        done_out    <= 1'b1;
        illegal_out <= bad_mode;
        ea_out      <= d.ea;
        len_out     <= d.len;
        result_out  <= res_nxt;
        taken_out   <= d.taken && !bad_mode;
        pc_out      <= (d.taken && !bad_mode) ? d.target : pc_in;
      end
    end
  end

  // flags shown straight from the held register
  assign cc_out = cc_r;

  // checks beside the logic
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_rmw_long_refused: assert property (
    accept && is_rmw(op_in) && is_long(mode_in) |=> illegal_out)
    else $error("long mode accepted for rewrite");

  a_short_page_zero: assert property (
    accept && mode_in == M_SDIR |=> ea_out[15:8] == 8'h00)
    else $error("short direct left page zero");

  a_long_full_addr: assert property (
    accept && mode_in == M_LDIR && !is_rmw(op_in)
    |=> ea_out == {$past(byte1_in), $past(byte2_in)} && len_out == 3'h2)
    else $error("long direct address wrong");

  a_y_prefix_len: assert property (
    accept && mode_in == M_NOIDX
    |=> len_out == ($past(idx_y_in) ? 3'h1 : 3'h0))
    else $error("no-offset index length wrong");

  a_rel_target: assert property (
    accept && op_in == OP_JUMP_REL && mode_in == M_RELD &&
    cond_in == C_ALWAYS
    |=> pc_out == $past(pc_in) + {{8{$past(byte1_in[7])}},
                                   $past(byte1_in)})
    else $error("relative target wrong");

  a_bit_compare_flags: assert property (
    accept && op_in == OP_BIT_COMPARE
    |=> cc_out[FLAG_Z] == ($past(and_val) == 8'h00) &&
        cc_out[FLAG_C] == $past(cc_r[FLAG_C]) &&
        cc_out[FLAG_H] == $past(cc_r[FLAG_H]))
    else $error("bit compare flags wrong");

  a_return_pop_seq: assert property (
    accept && op_in == OP_INTERRUPT_RETURN && !bad_mode
    |=> stack_pop_out [*5] ##1 (!stack_pop_out && done_out))
    else $error("stack pop sequence wrong");

  a_ugt_branch: assert property (
    accept && op_in == OP_JUMP_REL && cond_in == C_UNSIGNED_GREATER &&
    !bad_mode
    |=> taken_out == !($past(cc_r[FLAG_C]) | $past(cc_r[FLAG_Z])))
    else $error("unsigned greater decision wrong");

  a_ext_line_jump: assert property (
    accept && op_in == OP_JUMP_REL && cond_in == C_EXT_LINE_LOW
    |=> taken_out == !$past(ext_line_in))
    else $error("external line jump wrong");

  a_btj_carry: assert property (
    accept && op_in == OP_BTJT && !bad_mode
    |=> cc_out[FLAG_C] == taken_out)
    else $error("tested bit not in carry");

  a_jump_keeps_flags: assert property (
    accept && op_in == OP_JUMP_REL |=> cc_out == $past(cc_r))
    else $error("jump altered flags");

  c_return_done: cover property (
    accept && op_in == OP_INTERRUPT_RETURN ##6 done_out);
  c_btjf_taken: cover property (
    accept && op_in == OP_BTJF ##1 taken_out);
  c_long_index: cover property (
    accept && mode_in == M_LINDX && idx_y_in);
  c_rmw_refused: cover property (illegal_out);

endmodule

// ==== bench/addr_flag_decode_tb_top.sv ====
`timescale 1ns/1ps
module addr_flag_decode_tb_top;
  import decode_pkg::*;

  logic        clk;
  logic        nrst;
  logic        valid;
  op_t         op;
  mode_t       mode;
  cond_t       cond;
  logic        idx_y;
  logic        ext;
  logic [7:0]  b1, b2, acc, xr, yr, mem, stk;
  logic [2:0]  bsel;
  logic [15:0] ptr, pc;
  logic        done, busy, ill, taken, pop;
  logic [15:0] ea, pco;
  logic [2:0]  len;
  logic [7:0]  res, acco, xo;
  logic [4:0]  cco;
  logic [4:0]  ecc;
  int          fail_count;
  int          comparisons;

  addr_flag_decode uut (
    .clk_in(clk), .nrst_in(nrst), .valid_in(valid), .op_in(op),
    .mode_in(mode), .cond_in(cond), .idx_y_in(idx_y), .byte1_in(b1),
    .byte2_in(b2), .ptr_in(ptr), .acc_in(acc), .x_in(xr), .y_in(yr),
    .pc_in(pc), .mem_in(mem), .bit_sel_in(bsel), .ext_line_in(ext),
    .stack_data_in(stk), .done_out(done), .busy_out(busy),
    .illegal_out(ill), .ea_out(ea), .len_out(len), .taken_out(taken),
    .pc_out(pco), .result_out(res), .cc_out(cco), .acc_out(acco),
    .x_out(xo), .stack_pop_out(pop)
  );

  // free running core clock, 25 ns period
  always #12.5 clk = ~clk;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task conclude;
    $display("counts: %0d mismatches, %0d comparisons", fail_count,
             comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one request after an idle edge, so valid never toggles in one step
  task automatic send(input op_t o, input mode_t m);
    int k;
    @(posedge clk);
    #1 op = o;
    mode = m;
    valid = 1'b1;
    @(posedge clk);
    #1 valid = 1'b0;
    for (k = 0; k < 4 && done !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk(16'(done), 16'h0001);
  endtask

  // own reference for the jump conditions
  function automatic logic exp_tk(cond_t c, logic [4:0] f, logic e);
    case (c)
      C_ALWAYS:           return 1'b1;
      C_EQUAL:            return f[FLAG_Z];
      C_NOT_EQUAL:        return !f[FLAG_Z];
      C_MINUS:            return f[FLAG_N];
      C_PLUS:             return !f[FLAG_N];
      C_CARRY_SET:        return f[FLAG_C];
      C_CARRY_CLEAR:      return !f[FLAG_C];
      C_HALF_SET:         return f[FLAG_H];
      C_HALF_CLEAR:       return !f[FLAG_H];
      C_MASK_SET:         return f[FLAG_I];
      C_MASK_CLEAR:       return !f[FLAG_I];
      C_UNSIGNED_GREATER: return !(f[FLAG_C] | f[FLAG_Z]);
      C_EXT_LINE_HIGH:    return e;
      C_EXT_LINE_LOW:     return !e;
      default:            return 1'b0;
    endcase
  endfunction

  // operand length of every mode, x index
  task automatic t_lengths;
    logic [2:0] lens [17];
    int i;
    lens = '{0, 1, 1, 2, 0, 1, 2, 2, 2, 2, 2, 1, 2, 1, 2, 2, 3};
    idx_y = 1'b0;
    for (i = 0; i < 17; i++)
    begin
      send(OP_LOAD, mode_t'(i));
      chk(16'(len), 16'(lens[i]));
    end
    send(OP_LOAD, M_NOIDX);
    chk(ea, {8'h00, xr});
    idx_y = 1'b1;
    send(OP_LOAD, M_NOIDX);
    chk(16'(len), 16'h0001);
    chk(ea, {8'h00, yr});
    idx_y = 1'b0;
    $display("test lengths done");
  endtask

  // top of page zero against full long reach
  task automatic t_direct;
    b1 = 8'hFF;
    b2 = 8'h5A;
    send(OP_LOAD, M_LDIR);
    chk(ea, 16'hFF5A);
    send(OP_LOAD, M_SDIR);
    chk(ea, 16'h00FF);
    $display("test direct done");
  endtask

  // every rewrite op refused in long form, flags kept
  task automatic t_rmw;
    op_t ops [15];
    int i;
    ops = '{OP_CLR, OP_COMPLEMENT, OP_NEG, OP_BSET, OP_BRES, OP_BTJT,
            OP_BTJF, OP_INC, OP_DEC, OP_RLC, OP_RRC, OP_SLL, OP_SRL,
            OP_SRA, OP_SWAP};
    for (i = 0; i < 15; i++)
    begin
      send(ops[i], M_LDIR);
      chk(16'(ill), 16'h0001);
      chk(16'(cco), 16'(ecc));
    end
    mem = 8'h0F;
    send(OP_COMPLEMENT, M_SDIR);
    chk(16'(ill), 16'h0000);
    chk(16'(res), 16'h00F0);
    ecc = {ecc[4:3], 3'h5};
    chk(16'(cco), 16'(ecc));
    send(OP_CLR, M_SDIR);
    chk(16'(res), 16'h0000);
    ecc = {ecc[4:3], 2'h1, ecc[0]};
    chk(16'(cco), 16'(ecc));
    $display("test rmw done");
  endtask

  // both ends of the relative reach
  task automatic t_rel;
    pc = 16'h1000;
    cond = C_ALWAYS;
    b1 = 8'h80;
    send(OP_JUMP_REL, M_RELD);
    chk(pco, 16'h0F80);
    b1 = 8'h7F;
    send(OP_JUMP_REL, M_RELD);
    chk(pco, 16'h107F);
    $display("test relative done");
  endtask

  // pop walk; a request during busy must get no answer
  task automatic do_return(input logic [7:0] c, input logic [7:0] a,
                         input logic [7:0] x, input logic [15:0] p);
    logic [7:0] seq [5];
    int k;
    seq = '{c, a, x, p[15:8], p[7:0]};
    @(posedge clk);
    #1 op = OP_INTERRUPT_RETURN;
    mode = M_INH;
    valid = 1'b1;
    @(posedge clk);
    // each stack byte stands before the edge that ends its pop cycle
    #1 chk(16'(pop), 16'h0001);
    for (k = 0; k < 5; k++)
    begin
      stk = seq[k];
      valid = (k == 2);
      op = (k == 2) ? OP_LOAD : OP_INTERRUPT_RETURN;
      @(posedge clk);
      #1 chk(16'(busy), 16'(k < 4));
      chk(16'(done), 16'(k == 4));
    end
    stk = ~seq[4];
    chk(16'(done), 16'h0001);
    ecc = c[4:0];
    chk(16'(cco), 16'(ecc));
    chk(16'(acco), 16'(a));
    chk(16'(xo), 16'(x));
    chk(pco, p);
    @(posedge clk);
    #1 chk(16'(done), 16'h0000);
    $display("test return done");
  endtask

  // result tested, only n and z follow, accumulator untouched
  task automatic t_bitcmp;
    acc = 8'h0F;
    mem = 8'hF0;
    send(OP_BIT_COMPARE, M_SDIR);
    ecc = {ecc[4:3], 2'h1, ecc[0]};
    chk(16'(cco), 16'(ecc));
    chk(16'(acco), 16'h00A5);
    $display("test bit compare done");
  endtask

  // all conditions, both line levels
  task automatic t_cond;
    int e;
    int i;
    logic t;
    b1 = 8'h10;
    pc = 16'h2000;
    for (e = 0; e < 2; e++)
    begin
      for (i = 0; i < 15; i++)
      begin
        ext = e[0];
        cond = cond_t'(i);
        t = exp_tk(cond, ecc, ext);
        send(OP_JUMP_REL, M_RELD);
        chk(16'(taken), 16'(t));
        chk(pco, t ? 16'h2010 : 16'h2000);
        chk(16'(cco), 16'(ecc));
      end
    end
    $display("test conditions done");
  endtask

  // bit set and clear, both variants, bit copied to carry
  task automatic t_btj;
    int i;
    logic bv;
    logic t;
    mem = 8'h20;
    b1 = 8'h44;
    b2 = 8'hFE;
    pc = 16'h3000;
    for (i = 0; i < 4; i++)
    begin
      bsel = i[0] ? 3'h4 : 3'h5;
      bv = mem[bsel];
      t = i[1] ? !bv : bv;
      send(i[1] ? OP_BTJF : OP_BTJT, M_BITDR);
      chk(16'(taken), 16'(t));
      chk(pco, t ? 16'h2FFE : 16'h3000);
      chk(ea, 16'h0044);
      ecc = {ecc[4:1], bv};
      chk(16'(cco), 16'(ecc));
    end
    $display("test bit jumps done");
  endtask

  // main sequence
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    valid = 1'b0;
    op = OP_LOAD;
    mode = M_INH;
    cond = C_ALWAYS;
    {idx_y, ext, bsel} = 5'h00;
    {b1, b2, acc, mem, stk} = 40'h0;
    xr = 8'h37;
    yr = 8'hC9;
    ptr = 16'h0000;
    pc = 16'h0000;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    ecc = CC_RESET;
    chk(16'(cco), 16'h0008);
    t_lengths();
    t_direct();
    t_rmw();
    t_rel();
    do_return(8'h15, 8'hA5, 8'h3C, 16'h1234);
    t_cond();
    t_bitcmp();
    do_return(8'h08, 8'hA5, 8'h3C, 16'h4321);
    t_cond();
    t_btj();
    conclude();
  end

  // hang guard, about seventeen times the expected run
  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule
